/* src/acd_defs.vh */
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// Task file offsets on the register port
`define ACD_OFF_DATA     4'h0
`define ACD_OFF_FEAT_ERR 4'h1
`define ACD_OFF_SCNT     4'h2
`define ACD_OFF_SNUM     4'h3
`define ACD_OFF_CYL_LO   4'h4
`define ACD_OFF_CYL_HI   4'h5
`define ACD_OFF_DRVHD    4'h6
`define ACD_OFF_CMD_STAT 4'h7
`define ACD_OFF_DEVCTL   4'h8

// Status register bit positions
`define ACD_ST_BUSY 7
`define ACD_ST_RDY  6
`define ACD_ST_DSC  4
`define ACD_ST_DRQ  3
`define ACD_ST_ERR  0

// Drive/head and device control fields
`define ACD_DH_LBA   6
`define ACD_DH_DRIVE 4
`define ACD_DC_SRST  2
`define ACD_DC_NIEN  1

// Error register values
`define ACD_ERR_DIAG_OK 8'h01
`define ACD_ERR_ABORT   8'h04

// Reset values
`define ACD_RST_SCNT  8'h01
`define ACD_RST_SNUM  8'h01
`define ACD_RST_DRVHD 8'hA0

// Command codes decoded here; only check power is answered locally
`define ACD_CMD_CHKPWR_A 8'hE5
`define ACD_CMD_CHKPWR_B 8'h98
`define ACD_CMD_DIAG     8'h90
`define ACD_CMD_ERASE    8'hC0
`define ACD_CMD_FORMAT   8'h50
`define ACD_CMD_SETFEAT  8'hEF

// Power mode answers in the sector count register
`define ACD_PWR_STANDBY 8'h00
`define ACD_PWR_ACTIVE  8'hFF

// Timing
`define ACD_CLK_KHZ      10000
`define ACD_T_BSY_NS     400
`define ACD_T_DRQ2_US    700
`define ACD_T_DRQ3_MS    20
`define ACD_BSY_CYC      ((`ACD_T_BSY_NS * `ACD_CLK_KHZ) / 1000000)
`define ACD_DRQ2_CYC     ((`ACD_T_DRQ2_US * `ACD_CLK_KHZ) / 1000)
`define ACD_DRQ3_CYC     (`ACD_T_DRQ3_MS * `ACD_CLK_KHZ)
`define ACD_SECTOR_BYTES 512

`endif

/* src/acd_top.v */
// Function
// - Both opcodes accepted for every power command
// - C5h and CDh decode as class 3
// - Listed write commands and format are class 2
// - Only marked task file registers are used; count still sets E8h/32h/33h sectors, block-mode 50h passes sector number
// - Drive-only mark ignores the head field
// - Marked media commands accept block addressing
// - Check power in standby loads 00h, interrupts
// - Check power when active loads FFh, interrupts
// - Command 90h starts internal diagnostics
// - Diagnostic completion leaves 01h in error
// - C0h erases addressed sectors over count
// - Erased sectors read back as zero
// - 50h fills addressed track with pattern
// - Format takes one sector buffer like writes
// - Format buffer data is discarded
// - Format in block mode counts sectors, 0=256
// - Features used only by Set Features
// - 1Xh recalibrate, 7Xh seek, low nibble ignored
// - Class 1 sets busy within 400 ns
// - Class 2 raises data request within 700 us
// - Class 3 raises data request within 20 ms
//
// Chosen here: strobed register access and the address map.
`include "acd_defs.vh"

module acd_top #(
    parameter DRQ2_CYCLES = `ACD_DRQ2_CYC,
    parameter DRQ3_CYCLES = `ACD_DRQ3_CYC
) (
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         intrq_out,
    input  wire        pwr_standby_in,
    output reg         op_start_out,
    output reg  [7:0]  op_code_out,
    output reg         op_block_mode_out,
    output reg  [27:0] op_address_out,
    output reg  [8:0]  op_count_out,
    output reg         op_drive_out,
    output reg  [7:0]  op_features_out,
    input  wire        op_done_in,
    input  wire        op_error_in,
    output reg         buf_prep_out,
    input  wire        buf_ready_in,
    output reg         buf_wvalid_out,
    output reg  [7:0]  buf_wdata_out,
    output reg         buf_rpop_out,
    input  wire [7:0]  buf_rdata_in,
    input  wire        sector_erased_in
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_LOCAL = 3'd1;
    localparam [2:0] ST_PREP = 3'd2;
    localparam [2:0] ST_XFER = 3'd3;
    localparam [2:0] ST_EXEC = 3'd4;
    localparam [2:0] ST_ABORT = 3'd5;

    localparam [1:0] CLS_NONE = 2'd0;
    localparam [1:0] CLS_ONE = 2'd1;
    localparam [1:0] CLS_TWO = 2'd2;
    localparam [1:0] CLS_THREE = 2'd3;

    // Use mask bits: {block ok, features, count, number, cylinder, head, drive}
    localparam [6:0] USE_DRV = 7'b0000001;
    localparam [6:0] USE_ALL = 7'b1011111;
    localparam [6:0] USE_ADR = 7'b1001111;

    // Command class; dual power codes and nibble-wildcard codes decode here
    function [1:0] acd_class;
        input [7:0] code;
        begin
            case (code)
                8'hE5, 8'h98, 8'hE6, 8'h99, 8'hE3, 8'h97, 8'hE1, 8'h95,
                8'hE2, 8'h96, 8'hE0, 8'h94: acd_class = CLS_ONE;
                8'h90, 8'hC0, 8'hEC, 8'h91, 8'hE4, 8'hC4, 8'h22, 8'h23,
                8'h20, 8'h21, 8'h40, 8'h41, 8'h03, 8'hEF, 8'hC6, 8'h87,
                8'hF5: acd_class = CLS_ONE;
                8'h30, 8'h31, 8'h38, 8'h3C, 8'hE8, 8'h32, 8'h33,
                8'h50: acd_class = CLS_TWO;
                8'hC5, 8'hCD: acd_class = CLS_THREE;
                default: begin
                    if (code[7:4] == 4'h1 || code[7:4] == 4'h7) begin
                        acd_class = CLS_ONE;
                    end else begin
                        acd_class = CLS_NONE;
                    end
                end
            endcase
        end
    endfunction

    // Which task file registers carry parameters for a code
    function [6:0] acd_uses;
        input [7:0] code;
        begin
            case (code)
                8'hC0, 8'hC4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87, 8'hC5,
                8'hCD, 8'h30, 8'h31, 8'h38, 8'h3C: acd_uses = USE_ALL;
                8'h22, 8'h23, 8'h32, 8'h33: acd_uses = USE_ADR;
                8'h50: acd_uses = 7'b1010111;
                8'h91: acd_uses = 7'b0010011;
                8'hF5: acd_uses = 7'b0000011;
                8'hE3, 8'h97, 8'hC6: acd_uses = 7'b0010001;
                8'hEF: acd_uses = 7'b0100001;
                8'h90: acd_uses = 7'b0000000;
                default: begin
                    if (code[7:4] == 4'h7) begin
                        acd_uses = USE_ADR;
                    end else begin
                        acd_uses = USE_DRV;
                    end
                end
            endcase
        end
    endfunction

    reg [7:0]  feat_ff;
    reg [7:0]  scnt_ff;
    reg [7:0]  snum_ff;
    reg [7:0]  cyl_lo_ff;
    reg [7:0]  cyl_hi_ff;
    reg [7:0]  drvhd_ff;
    reg [7:0]  err_ff;
    reg [7:0]  cmd_ff;
    reg        nien_ff;
    reg        srst_ff;
    reg        bsy_ff;
    reg        rdy_ff;
    reg        drq_ff;
    reg        errbit_ff;
    reg [2:0]  state_ff;
    reg [9:0]  byte_cnt_ff;
    reg [8:0]  sect_left_ff;
    reg [17:0] tmr_ff;

    wire [1:0] new_class = acd_class(reg_wdata_in);
    wire [6:0] cur_use = acd_uses(cmd_ff);
    wire       cmd_wr = reg_wr_in && (reg_addr_in == `ACD_OFF_CMD_STAT);
    wire       data_wr = reg_wr_in && (reg_addr_in == `ACD_OFF_DATA);
    wire       stat_rd = reg_rd_in && (reg_addr_in == `ACD_OFF_CMD_STAT);
    wire       blk_mode = drvhd_ff[`ACD_DH_LBA] && cur_use[6];
    wire [8:0] cnt_full = (scnt_ff == 8'h00) ? 9'h100 : {1'b0, scnt_ff};
    wire       last_byte = (byte_cnt_ff == 10'd`ACD_SECTOR_BYTES - 10'd1);
    wire       format_cmd = (cmd_ff == `ACD_CMD_FORMAT);
    wire [17:0] drq_limit = (acd_class(cmd_ff) == CLS_THREE) ?
                            DRQ3_CYCLES[17:0] : DRQ2_CYCLES[17:0];
    wire [7:0] status = {bsy_ff, rdy_ff, 1'b0, rdy_ff, drq_ff, 1'b0, 1'b0, errbit_ff};

    // Register reads, answer in the following cycle only
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
            buf_rpop_out <= 1'b0;
        end else begin
            buf_rpop_out <= reg_rd_in && (reg_addr_in == `ACD_OFF_DATA);
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `ACD_OFF_DATA:
                        reg_rdata_out <= sector_erased_in ? 8'h00 : buf_rdata_in;
                    `ACD_OFF_FEAT_ERR: reg_rdata_out <= err_ff;
                    `ACD_OFF_SCNT: reg_rdata_out <= scnt_ff;
                    `ACD_OFF_SNUM: reg_rdata_out <= snum_ff;
                    `ACD_OFF_CYL_LO: reg_rdata_out <= cyl_lo_ff;
                    `ACD_OFF_CYL_HI: reg_rdata_out <= cyl_hi_ff;
                    `ACD_OFF_DRVHD: reg_rdata_out <= drvhd_ff;
                    `ACD_OFF_CMD_STAT: reg_rdata_out <= status;
                    `ACD_OFF_DEVCTL: reg_rdata_out <= status;
                    default: reg_rdata_out <= 8'h00;
                endcase
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    // Device control; soft reset holds the engine idle while set
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            nien_ff <= 1'b0;
            srst_ff <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == `ACD_OFF_DEVCTL) begin
            nien_ff <= reg_wdata_in[`ACD_DC_NIEN];
            srst_ff <= reg_wdata_in[`ACD_DC_SRST];
        end
    end

    // Command engine and task file
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            feat_ff <= 8'h00;
            scnt_ff <= `ACD_RST_SCNT;
            snum_ff <= `ACD_RST_SNUM;
            cyl_lo_ff <= 8'h00;
            cyl_hi_ff <= 8'h00;
            drvhd_ff <= `ACD_RST_DRVHD;
            err_ff <= `ACD_ERR_DIAG_OK;
            cmd_ff <= 8'h00;
            bsy_ff <= 1'b0;
            rdy_ff <= 1'b1;
            drq_ff <= 1'b0;
            errbit_ff <= 1'b0;
            state_ff <= ST_IDLE;
            byte_cnt_ff <= 10'h000;
            sect_left_ff <= 9'h000;
            tmr_ff <= 18'h00000;
            intrq_out <= 1'b0;
            op_start_out <= 1'b0;
            op_code_out <= 8'h00;
            op_block_mode_out <= 1'b0;
            op_address_out <= 28'h0000000;
            op_count_out <= 9'h000;
            op_drive_out <= 1'b0;
            op_features_out <= 8'h00;
            buf_prep_out <= 1'b0;
            buf_wvalid_out <= 1'b0;
            buf_wdata_out <= 8'h00;
        end else if (srst_ff) begin
            // Drive stays busy until software drops soft reset
            state_ff <= ST_IDLE;
            bsy_ff <= 1'b1;
            drq_ff <= 1'b0;
            errbit_ff <= 1'b0;
            err_ff <= `ACD_ERR_DIAG_OK;
            intrq_out <= 1'b0;
            op_start_out <= 1'b0;
            buf_prep_out <= 1'b0;
            buf_wvalid_out <= 1'b0;
        end else begin
            op_start_out <= 1'b0;
            buf_prep_out <= 1'b0;
            buf_wvalid_out <= 1'b0;
            if (state_ff == ST_IDLE && bsy_ff) begin
                bsy_ff <= 1'b0;
            end
            // Task file writes are accepted only while the engine is idle
            if (reg_wr_in && !bsy_ff && !drq_ff) begin
                case (reg_addr_in)
                    `ACD_OFF_FEAT_ERR: feat_ff <= reg_wdata_in;
                    `ACD_OFF_SCNT: scnt_ff <= reg_wdata_in;
                    `ACD_OFF_SNUM: snum_ff <= reg_wdata_in;
                    `ACD_OFF_CYL_LO: cyl_lo_ff <= reg_wdata_in;
                    `ACD_OFF_CYL_HI: cyl_hi_ff <= reg_wdata_in;
                    `ACD_OFF_DRVHD: drvhd_ff <= reg_wdata_in;
                    default: ;
                endcase
            end
            // Interrupt drops on status read or new command; a raise wins
            if (stat_rd || cmd_wr) begin
                intrq_out <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (cmd_wr && !bsy_ff && !drq_ff) begin
                        cmd_ff <= reg_wdata_in;
                        bsy_ff <= 1'b1;
                        errbit_ff <= 1'b0;
                        tmr_ff <= 18'h00000;
                        if (new_class == CLS_NONE) begin
                            state_ff <= ST_ABORT;
                        end else if (new_class == CLS_ONE) begin
                            state_ff <= ST_LOCAL;
                        end else begin
                            state_ff <= ST_PREP;
                            buf_prep_out <= 1'b1;
                        end
                    end
                end
                ST_LOCAL: begin
                    // Parameters masked to the registers the code marks, save the full address sent in block mode
                    op_code_out <= cmd_ff;
                    op_block_mode_out <= blk_mode;
                    if (blk_mode) begin
                        op_address_out <= {drvhd_ff[3:0], cyl_hi_ff, cyl_lo_ff, snum_ff};
                    end else begin
                        op_address_out <= {(cur_use[1] ? drvhd_ff[3:0] : 4'h0),
                                           (cur_use[2] ? {cyl_hi_ff, cyl_lo_ff} : 16'h0000),
                                           (cur_use[3] ? snum_ff : 8'h00)};
                    end
                    op_count_out <= cur_use[4] ? cnt_full : 9'h000;
                    op_drive_out <= cur_use[0] ? drvhd_ff[`ACD_DH_DRIVE] : 1'b0;
                    op_features_out <= cur_use[5] ? feat_ff : 8'h00;
                    if (cmd_ff == `ACD_CMD_CHKPWR_A || cmd_ff == `ACD_CMD_CHKPWR_B) begin
                        if (pwr_standby_in) begin
                            scnt_ff <= `ACD_PWR_STANDBY;
                        end else begin
                            scnt_ff <= `ACD_PWR_ACTIVE;
                        end
                        bsy_ff <= 1'b0;
                        intrq_out <= !nien_ff;
                        state_ff <= ST_IDLE;
                    end else begin
                        // Diagnostic, erase, seek and the rest run outside
                        op_start_out <= 1'b1;
                        state_ff <= ST_EXEC;
                    end
                end
                ST_PREP: begin
                    tmr_ff <= tmr_ff + 18'h00001;
                    // Limit forces the request so the host is never left waiting
                    if (buf_ready_in || tmr_ff >= drq_limit - 18'h00001) begin
                        drq_ff <= 1'b1;
                        bsy_ff <= 1'b0;
                        byte_cnt_ff <= 10'h000;
                        state_ff <= ST_XFER;
                        if (sect_left_ff == 9'h000) begin
                            sect_left_ff <= (format_cmd && !blk_mode) ? 9'h001 : cnt_full;
                        end
                    end
                end
                ST_XFER: begin
                    if (data_wr) begin
                        // Same handshake for format, but its bytes go nowhere
                        buf_wvalid_out <= !format_cmd;
                        buf_wdata_out <= reg_wdata_in;
                        byte_cnt_ff <= byte_cnt_ff + 10'h001;
                        if (last_byte) begin
                            drq_ff <= 1'b0;
                            bsy_ff <= 1'b1;
                            state_ff <= ST_LOCAL;
                        end
                    end
                end
                ST_EXEC: begin
                    if (op_done_in) begin
                        if (cmd_ff == `ACD_CMD_DIAG) begin
                            err_ff <= `ACD_ERR_DIAG_OK;
                        end else if (op_error_in) begin
                            err_ff <= `ACD_ERR_ABORT;
                            errbit_ff <= 1'b1;
                        end else begin
                            err_ff <= 8'h00;
                        end
                        // Format writes its pattern over the whole span at once
                        if (acd_class(cmd_ff) != CLS_ONE && !format_cmd &&
                            sect_left_ff > 9'h001 && !op_error_in) begin
                            sect_left_ff <= sect_left_ff - 9'h001;
                            tmr_ff <= 18'h00000;
                            buf_prep_out <= 1'b1;
                            state_ff <= ST_PREP;
                        end else begin
                            sect_left_ff <= 9'h000;
                            bsy_ff <= 1'b0;
                            intrq_out <= !nien_ff;
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ABORT: begin
                    err_ff <= `ACD_ERR_ABORT;
                    errbit_ff <= 1'b1;
                    bsy_ff <= 1'b0;
                    intrq_out <= !nien_ff;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

endmodule // acd_top

/* verif/acd_top_props.sv */
module acd_top_props (
    input wire logic        sys_clk_in,
    input wire logic        resetn_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        op_start_out,
    input wire logic [7:0]  op_code_out,
    input wire logic        op_block_mode_out,
    input wire logic [27:0] op_address_out,
    input wire logic [8:0]  op_count_out,
    input wire logic [7:0]  op_features_out,
    input wire logic        buf_wvalid_out,
    input wire logic [7:0]  buf_wdata_out,
    input wire logic        sector_erased_in
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Parameter fields seen at the moment an operation starts
    AST_FEAT_IGNORED: assert property (op_start_out && op_code_out != 8'hEF
        |-> op_features_out == 8'h00) else $error("features leaked to other command");
    AST_FMT_COUNT: assert property (op_start_out && op_code_out == 8'h50 && op_block_mode_out
        |-> op_count_out inside {[1:256]}) else $error("format count out of range");
    AST_ERASE_COUNT: assert property (op_start_out && op_code_out == 8'hC0
        |-> op_count_out != 9'h000) else $error("erase count zero");
    AST_RECAL_NO_ADDR: assert property (op_start_out && op_code_out[7:4] == 4'h1
        |-> op_address_out == 28'h0000000 && op_count_out == 9'h000)
        else $error("recalibrate used address fields");
    AST_SEEK_NO_COUNT: assert property (op_start_out && op_code_out[7:4] == 4'h7
        |-> op_count_out == 9'h000) else $error("seek used sector count");
    AST_BLOCK_MODE_CMD: assert property (op_start_out && op_block_mode_out
        |-> op_code_out[7:4] == 4'h7 || op_code_out inside {8'hC0, 8'h50, 8'h20, 8'h21,
        8'h22, 8'h23, 8'h40, 8'h41, 8'hC4, 8'h87, 8'h30, 8'h31, 8'h32, 8'h33, 8'h38,
        8'h3C, 8'hC5, 8'hCD}) else $error("block mode on unmarked command");

    // Data path relations across one cycle
    AST_ERASED_ZERO: assert property ($past(reg_rd_in && reg_addr_in == 4'h0
        && sector_erased_in) |-> reg_rdata_out == 8'h00) else $error("erased read not zero");
    AST_WVALID_DATA: assert property (buf_wvalid_out |-> $past(reg_wr_in)
        && $past(reg_addr_in) == 4'h0 && buf_wdata_out == $past(reg_wdata_in))
        else $error("buffer byte without matching host write");

    COV_FORMAT: cover property (op_start_out && op_code_out == 8'h50);
    COV_SEEK: cover property (op_start_out && op_code_out[7:4] == 4'h7);
    COV_WBYTE: cover property (buf_wvalid_out);
endmodule // acd_top_props

bind acd_top acd_top_props i_acd_top_props (.sys_clk_in, .resetn_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .op_start_out, .op_code_out,
    .op_block_mode_out, .op_address_out, .op_count_out, .op_features_out,
    .buf_wvalid_out, .buf_wdata_out, .sector_erased_in);

/* verif/acd_media_model.sv */
module acd_media_model (
    input  wire logic       sys_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       op_start_in,
    input  wire logic [7:0] op_code_in,
    input  wire logic       buf_prep_in,
    input  wire logic       erased_mode_in,
    output logic            op_done_out,
    output logic            op_error_out,
    output logic            buf_ready_out,
    output logic [7:0]      buf_rdata_out,
    output logic            sector_erased_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0]  op_dly_ff;
    logic [29:0] buf_dly_ff;

    // Slow buffer, longer than the class 2 limit, so the forced path is hit
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            op_dly_ff     <= 5'h00;
            buf_dly_ff    <= 30'h0;
            op_done_out   <= 1'b0;
            op_error_out  <= 1'b0;
            buf_ready_out <= 1'b0;
            buf_rdata_out <= 8'hA5;
        end else begin
            op_dly_ff     <= {op_dly_ff[3:0], op_start_in};
            buf_dly_ff    <= {buf_dly_ff[28:0], buf_prep_in};
            op_done_out   <= op_dly_ff[4];
            op_error_out  <= op_dly_ff[4] && op_code_in == 8'h90;
            buf_ready_out <= buf_dly_ff[29];
            buf_rdata_out <= buf_rdata_out + 8'h3B; // Never settles, so stale data shows
        end
    end

    assign sector_erased_out = erased_mode_in;
endmodule // acd_media_model

/* verif/acd_top_tb.sv */
module acd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D2 = 20;
    localparam int D3 = 40;
    logic        sys_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        pwr_standby_in = 1'b0;
    logic        erased_mode = 1'b0;
    wire  [7:0]  reg_rdata_out, op_code_out, op_features_out, buf_wdata_out, buf_rdata_in;
    wire  [27:0] op_address_out;
    wire  [8:0]  op_count_out;
    wire         intrq_out, op_start_out, op_block_mode_out, op_drive_out, op_done_in;
    wire         op_error_in, buf_prep_out, buf_ready_in, buf_wvalid_out, buf_rpop_out;
    wire         sector_erased_in;
    int          bad_count = 0;
    int          checks_done = 0;
    int          wv_count = 0;
    int          rp_count = 0;
    logic [7:0]  s;
    logic [7:0]  codes[7] = '{8'h30, 8'h31, 8'h38, 8'h3C, 8'hE8, 8'hC5, 8'hCD};
    logic [7:0]  seeks[4] = '{8'h10, 8'h1F, 8'h7A, 8'h75};

    always #50 sys_clk_in = ~sys_clk_in;

    acd_top #(.DRQ2_CYCLES(D2), .DRQ3_CYCLES(D3)) i_acd_top (.sys_clk_in, .resetn_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .intrq_out,
        .pwr_standby_in, .op_start_out, .op_code_out, .op_block_mode_out, .op_address_out,
        .op_count_out, .op_drive_out, .op_features_out, .op_done_in, .op_error_in,
        .buf_prep_out, .buf_ready_in, .buf_wvalid_out, .buf_wdata_out, .buf_rpop_out,
        .buf_rdata_in, .sector_erased_in);

    acd_media_model i_acd_media_model (.sys_clk_in, .resetn_in, .op_start_in(op_start_out),
        .op_code_in(op_code_out), .buf_prep_in(buf_prep_out), .erased_mode_in(erased_mode),
        .op_done_out(op_done_in), .op_error_out(op_error_in), .buf_ready_out(buf_ready_in),
        .buf_rdata_out(buf_rdata_in), .sector_erased_out(sector_erased_in));

    // Bytes handed to and popped from the sector buffer
    always @(posedge sys_clk_in) begin
        if (buf_wvalid_out === 1'b1) wv_count++;
        if (buf_rpop_out === 1'b1) rp_count++;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in   <= 1'b0;
        #10 d = reg_rdata_out;
    endtask

    task automatic tf(input logic [7:0] sc, sn, cl, ch, dh);
        wr(4'h2, sc);
        wr(4'h3, sn);
        wr(4'h4, cl);
        wr(4'h5, ch);
        wr(4'h6, dh);
    endtask

    // Polls status; a hang shows as a failed compare
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300; i++) begin
            rd(4'h7, s);
            if (s[7] === 1'b0 && s[3] === 1'b0) break;
        end
        chk("idle", i < 300, 1);
    endtask

    task automatic wait_drq(input int lim);
        int i;
        for (i = 0; i < (lim + 8) / 2; i++) begin
            rd(4'h7, s);
            if (s[3] === 1'b1) break;
        end
        chk("data request", {s[7], s[3]}, 2'b01);
    endtask

    task automatic xfer();
        for (int i = 0; i < 512; i++) wr(4'h0, i[7:0]);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        int w0;
        repeat (10) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        rd(4'h7, s);
        chk("status", s, 8'h50);
        rd(4'h1, s);
        chk("error", s, 8'h01);
        rd(4'h6, s);
        chk("drive head", s, 8'hA0);
        rd(4'h9, s);
        chk("unmapped", s, 8'h00);
        // Both power codes in standby and in active
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            pwr_standby_in <= i[1];
            wr(4'h7, i[0] ? 8'h98 : 8'hE5);
            repeat (2) @(posedge sys_clk_in);
            #10 chk("power intrq", intrq_out, 1);
            rd(4'h2, s);
            chk("power mode", s, i[1] ? 8'h00 : 8'hFF);
            wait_idle();
        end
        wr(4'h8, 8'h02);
        wr(4'h7, 8'hE5);
        repeat (2) @(posedge sys_clk_in);
        #10 chk("masked intrq", intrq_out, 0);
        wr(4'h8, 8'h04);
        rd(4'h7, s);
        chk("soft reset", s, 8'hD0);
        wr(4'h8, 8'h00);
        wait_idle();
        wr(4'h7, 8'hFF);
        wait_idle();
        rd(4'h1, s);
        chk("abort error", s, 8'h04);
        wr(4'h1, 8'h5A);
        wr(4'h7, 8'hEF);
        wait_idle();
        chk("set features", op_features_out, 8'h5A);
        wr(4'h7, 8'h90);
        wait_idle();
        chk("diag code", op_code_out, 8'h90);
        rd(4'h1, s);
        chk("diag error", s, 8'h01);
        // Recalibrate and seek ignore the low nibble
        foreach (seeks[k]) begin
            tf(8'h03, 8'h11, 8'h22, 8'h33, 8'hB5);
            wr(4'h1, 8'h77);
            wr(4'h7, seeks[k]);
            wait_idle();
            chk("seek code", op_code_out, seeks[k]);
            chk("seek drive", op_drive_out, 1);
            chk("seek feat", op_features_out, 8'h00);
            chk("seek addr", op_address_out, seeks[k][6] ? 28'h5332211 : 28'h0);
        end
        tf(8'h00, 8'h44, 8'h55, 8'h66, 8'hE3);
        wr(4'h7, 8'hC0);
        wait_idle();
        chk("erase mode", op_block_mode_out, 1);
        chk("erase addr", op_address_out, 28'h3665544);
        chk("erase count", op_count_out, 9'd256);
        tf(8'h00, 8'h00, 8'h55, 8'h66, 8'hE2);
        wr(4'h7, 8'h50);
        wait_drq(D2);
        w0 = wv_count;
        xfer();
        wait_idle();
        chk("format bytes", wv_count - w0, 0);
        chk("format code", op_code_out, 8'h50);
        chk("format count", op_count_out, 9'd256);
        // Class 2 and class 3 writes, one sector each
        foreach (codes[k]) begin
            tf(8'h01, 8'h44, 8'h55, 8'h66, 8'hE3);
            wr(4'h7, codes[k]);
            wait_drq(codes[k][7:4] == 4'hC ? D3 : D2);
            w0 = wv_count;
            xfer();
            wait_idle();
            chk("write bytes", wv_count - w0, 512);
        end
        tf(8'h02, 8'h44, 8'h55, 8'h66, 8'hE3);
        wr(4'h7, 8'h30);
        w0 = wv_count;
        repeat (2) begin
            wait_drq(D3);
            xfer();
        end
        wait_idle();
        chk("multi bytes", wv_count - w0, 1024);
        @(posedge sys_clk_in);
        erased_mode <= 1'b1;
        rd(4'h0, s);
        chk("erased read", s, 8'h00);
        @(posedge sys_clk_in);
        #10 chk("pop", rp_count, 1);
        give_verdict();
    end

    // Whole run is near 11000 cycles
    initial begin
        #(60000 * 100);
        bad_count++;
        give_verdict();
    end
endmodule // acd_top_tb
